// *** core/fidr_pkg.sv ***
// constants and types of the flash identification and info-area command block
package fidr_pkg;
  // ************************************************************
  // timing
  // ************************************************************
  localparam int CLK_PERIOD_NS  = 5;
  localparam int RST_PULSE_NS   = 100;
  localparam int RST_PULSE_CYC  =
    (RST_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int ERASE_TIME_US  = 100;
  localparam int ERASE_CYC      = ERASE_TIME_US * 1000 / CLK_PERIOD_NS;
  localparam int REC_WRITE_NS   = 10000;
  localparam int REC_WRITE_CYC  = REC_WRITE_NS / CLK_PERIOD_NS;
  localparam int REC_OTHER_NS   = 1000;
  localparam int REC_OTHER_CYC  = REC_OTHER_NS / CLK_PERIOD_NS;
  localparam int DUMMY_CYC      = 8;
  localparam int CMD_BITS       = 8;
  localparam int ADDR_BITS      = 24;
  // ************************************************************
  // command codes
  // ************************************************************
  localparam logic [7:0] CMD_STD_IDENT  = 8'h9f;
  localparam logic [7:0] CMD_MAKER_DEV  = 8'h90;
  localparam logic [7:0] CMD_UNIQUE     = 8'h4b;
  localparam logic [7:0] CMD_PARAM_TBL  = 8'h5a;
  localparam logic [7:0] CMD_RST_ARM    = 8'h66;
  localparam logic [7:0] CMD_RST        = 8'h99;
  localparam logic [7:0] CMD_WL_SET     = 8'h06;
  localparam logic [7:0] CMD_AREA_ERASE = 8'h44;
  localparam logic [7:0] CMD_AREA_PROG  = 8'h42;
  // ************************************************************
  // info-area address fields
  // ************************************************************
  localparam int         AREA_SEL_LSB = 12;
  localparam logic [7:0] AREA_TOP_VAL = 8'h00;
  localparam logic [1:0] AREA_GAP_VAL = 2'h0;
  localparam logic [3:0] AREA_MIN     = 4'h1;
  localparam logic [3:0] AREA_MAX     = 4'h3;
  localparam logic [7:0] TBL_UNDEF    = 8'hff;
  localparam int         TBL_BYTES    = 16;
  // ************************************************************
  // types
  // ************************************************************
  typedef enum logic [2:0] {
    ST_CMD   = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DUMMY = 3'b010,
    ST_DATA  = 3'b011,
    ST_DONE  = 3'b100
  } fidr_state_t;
endpackage

// *** core/fidr_sync.sv ***
// two-flop synchroniser for pins from outside the clk_sys domain
`timescale 1ns/10ps
module fidr_sync #(
  parameter int               WIDTH   = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      meta <= RST_VAL;
      dout <= RST_VAL;
    end else begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // fidr_sync

// *** core/fidr_buf.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/10ps
module fidr_buf #(
  parameter int WIDTH = 8
) (
  input  wire logic             clk_sys,
  input  wire logic             rst,
  input  wire logic             flush,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  logic [WIDTH-1:0] mem [2];
  logic             wr_ptr;
  logic             rd_ptr;
  logic [1:0]       count;
  logic             push;
  logic             pop;

  assign in_ready  = (count != 2'h2);
  assign out_valid = (count != 2'h0);
  assign out_data  = mem[rd_ptr];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_ff @(posedge clk_sys) begin
    if (rst || flush) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end else begin
      if (push) wr_ptr <= ~wr_ptr;
      if (pop) rd_ptr <= ~rd_ptr;
      if (push && !pop) count <= count + 2'h1;
      else if (pop && !push) count <= count - 2'h1;
    end
  end

  // storage needs no reset: count guards every read
  always_ff @(posedge clk_sys) begin
    if (push) mem[wr_ptr] <= in_data;
  end
endmodule // fidr_buf

// *** core/fidr_core.sv ***
// serial flash identification, reset and info-area command interpreter
`timescale 1ns/10ps
// Operation
// - ident read gives maker then two-byte code
// - output bits change on falling clock edges
// - ident bytes repeat while select low
// - maker/device read takes three zero address bytes
// - maker/device read alternates maker and device
// - unique read: address, dummy, sixteen bytes
// - four-line unique read uses eight dummy cycles
// - unique bytes wrap while select low
// - unique start byte from address bits 3..0
// - table read: address, eight dummies, ends on select
// - reset arm then reset, else disarm
// - reset reloads volatile configuration
// - reset pin qualified by mode and disable
// - long reset pulse aborts, floats, keeps status
// - reset aborts erase, longer recovery after write
// - area program rejected while busy
// - three 1024-byte areas selected by address
// - set lock bit makes area read-only
// - erase needs latch and exact frame end
// - erase sets busy, clears latch
// - erase of locked area ignored
// - four-line command bytes as two nibbles
module fidr_core #(
  parameter int           ERASE_CYC  = fidr_pkg::ERASE_CYC,
  // identity values below are arbitrary
  parameter logic [7:0]   MAKER_CODE = 8'ha5,
  parameter logic [7:0]   TYPE_CODE  = 8'h3c,
  parameter logic [7:0]   CAP_CODE   = 8'h18,
  parameter logic [7:0]   DEV_CODE   = 8'h42,
  parameter logic [127:0] UNIQUE_NUM = 128'h0123456789abcdeffedcba9876543210,
  parameter logic [127:0] PARAM_TBL  = 128'h53464450010000ff000001ff30000000
) (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       sck,
  input  wire logic       cs_n,
  input  wire logic [3:0] io_in,
  output logic      [3:0] io_out,
  output logic      [3:0] io_oe,
  input  wire logic       reset_pin_n,
  input  wire logic       four_line_cmd_mode,
  input  wire logic       quad_lines_enable_bit,
  input  wire logic       dedicated_reset_pin,
  input  wire logic       reset_pin_disable,
  input  wire logic       info_area1_lock,
  input  wire logic       info_area2_lock,
  input  wire logic       info_area3_lock,
  output logic            busy_flag,
  output logic            write_latch,
  output logic            reload_cfg,
  output logic            erase_start,
  output logic            info_prog_start,
  output logic      [1:0] info_area_sel
);
  // ************************************************************
  // pin sampling
  // ************************************************************
  logic [6:0]              pins_s;
  logic                    sck_s, cs_s, rpin_n_s, sck_prev, cs_prev;
  logic [3:0]              io_s;
  logic                    quad, frame_rst, rise, fall, cs_rise, ev;
  fidr_pkg::fidr_state_t   st, next_st;
  logic [4:0]              cnt, next_cnt;
  logic [31:0]             sr, next_sr;
  logic [7:0]              cmd;
  logic [23:0]             addr;
  logic                    cmd_valid, over_run;

  fidr_sync #(.WIDTH(7), .RST_VAL(7'h60)) u_sync (
    .clk_sys (clk_sys),
    .rst     (rst),
    .din     ({reset_pin_n, cs_n, sck, io_in}),
    .dout    (pins_s)
  );
  assign {rpin_n_s, cs_s, sck_s, io_s} = pins_s;
  assign quad = four_line_cmd_mode;

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sck_prev <= 1'b0;
      cs_prev  <= 1'b1;
    end else begin
      sck_prev <= sck_s;
      cs_prev  <= cs_s;
    end
  end

  // ************************************************************
  // hardware reset pin
  // ************************************************************
  logic       hw_en, hw_act, hw_act_prev, rst_evt, sw_rst;
  logic       erasing, recovering, armed;
  logic [4:0] rlow_cnt;

  assign hw_en = dedicated_reset_pin ? !reset_pin_disable
                                     : (!quad && !quad_lines_enable_bit);
  assign hw_act = (rlow_cnt == 5'(fidr_pkg::RST_PULSE_CYC));

  always_ff @(posedge clk_sys) begin
    if (rst || rpin_n_s || !hw_en) rlow_cnt <= 5'h0;
    else if (!hw_act) rlow_cnt <= rlow_cnt + 5'h1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) hw_act_prev <= 1'b0;
    else hw_act_prev <= hw_act;
  end

  assign rst_evt = sw_rst || (hw_act && !hw_act_prev);

  // ************************************************************
  // frame decoder
  // ************************************************************
  // select high, reset pulse or recovery end the frame
  assign frame_rst = cs_s || hw_act || recovering;
  assign rise      = sck_s && !sck_prev && !frame_rst;
  assign fall      = !sck_s && sck_prev && !frame_rst;
  assign cs_rise   = cs_s && !cs_prev;
  assign ev        = cs_rise && cmd_valid && !hw_act && !recovering;

  function automatic logic fidr_last(input logic [4:0] c, input logic q,
                                     input int bits);
    fidr_last = (c == (q ? 5'(bits / 4 - 1) : 5'(bits - 1)));
  endfunction

  always_comb begin
    // four lines take a nibble per edge, upper first
    next_sr  = quad ? {sr[27:0], io_s} : {sr[30:0], io_s[0]};
    next_st  = st;
    next_cnt = cnt + 5'h1;
    unique case (st)
      fidr_pkg::ST_CMD: begin
        if (fidr_last(cnt, quad, fidr_pkg::CMD_BITS)) begin
          next_cnt = 5'h0;
          unique case (next_sr[7:0])
            fidr_pkg::CMD_STD_IDENT: next_st = fidr_pkg::ST_DATA;
            fidr_pkg::CMD_MAKER_DEV, fidr_pkg::CMD_UNIQUE,
            fidr_pkg::CMD_PARAM_TBL, fidr_pkg::CMD_AREA_ERASE,
            fidr_pkg::CMD_AREA_PROG: next_st = fidr_pkg::ST_ADDR;
            default: next_st = fidr_pkg::ST_DONE;
          endcase
        end
      end
      fidr_pkg::ST_ADDR: begin
        if (fidr_last(cnt, quad, fidr_pkg::ADDR_BITS)) begin
          next_cnt = 5'h0;
          // maker/device read streams right after its address
          if (cmd == fidr_pkg::CMD_MAKER_DEV) next_st = fidr_pkg::ST_DATA;
          else if (cmd == fidr_pkg::CMD_UNIQUE ||
                   cmd == fidr_pkg::CMD_PARAM_TBL)
            next_st = fidr_pkg::ST_DUMMY;
          else next_st = fidr_pkg::ST_DONE;
        end
      end
      // eight dummy cycles in either mode
      fidr_pkg::ST_DUMMY: begin
        if (cnt == 5'(fidr_pkg::DUMMY_CYC - 1)) begin
          next_cnt = 5'h0;
          next_st  = fidr_pkg::ST_DATA;
        end
      end
      fidr_pkg::ST_DATA, fidr_pkg::ST_DONE: next_cnt = cnt;
      default: next_st = fidr_pkg::ST_DONE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (rst || frame_rst) begin
      st  <= fidr_pkg::ST_CMD;
      cnt <= 5'h0;
      sr  <= 32'h0;
    end else if (rise) begin
      st  <= next_st;
      cnt <= next_cnt;
      sr  <= next_sr;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst || frame_rst) begin
      cmd_valid <= 1'b0;
      over_run  <= 1'b0;
    end else if (rise) begin
      if (st == fidr_pkg::ST_CMD && next_st != fidr_pkg::ST_CMD)
        cmd_valid <= 1'b1;
      // any clock after the address spoils an erase frame
      if (st == fidr_pkg::ST_DONE) over_run <= 1'b1;
    end
  end

  // cmd and addr hold their value across select rise for the events
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      cmd  <= 8'h00;
      addr <= 24'h0;
    end else if (rise && st == fidr_pkg::ST_CMD &&
                 next_st != fidr_pkg::ST_CMD) begin
      cmd <= next_sr[7:0];
    end else if (rise && st == fidr_pkg::ST_ADDR &&
                 next_st != fidr_pkg::ST_ADDR) begin
      addr <= next_sr[23:0];
    end
  end

  // ************************************************************
  // byte producer and output shifter
  // ************************************************************
  logic [23:0] paddr;
  logic        in_rdy, out_vld, pop, data_go;
  logic [7:0]  pbyte, obyte, shreg;
  logic [3:0]  bleft;

  function automatic logic [7:0] fidr_byte(input logic [7:0] c,
                                           input logic [23:0] a);
    fidr_byte = 8'h00;
    unique case (c)
      fidr_pkg::CMD_STD_IDENT:
        fidr_byte = (a[1:0] == 2'h0) ? MAKER_CODE :
                    (a[1:0] == 2'h1) ? TYPE_CODE : CAP_CODE;
      fidr_pkg::CMD_MAKER_DEV: fidr_byte = a[0] ? DEV_CODE : MAKER_CODE;
      fidr_pkg::CMD_UNIQUE: fidr_byte = UNIQUE_NUM[8'(a[3:0]) * 8 +: 8];
      fidr_pkg::CMD_PARAM_TBL:
        fidr_byte = (a < 24'(fidr_pkg::TBL_BYTES)) ?
                    PARAM_TBL[8'(a[3:0]) * 8 +: 8] : fidr_pkg::TBL_UNDEF;
      default: fidr_byte = 8'h00;
    endcase
  endfunction

  // only dummy-led reads load a start: cmd is stale until the command ends
  assign data_go = rise && next_st == fidr_pkg::ST_DATA &&
                   st == fidr_pkg::ST_DUMMY;
  assign pbyte   = fidr_byte(cmd, paddr);

  always_ff @(posedge clk_sys) begin
    if (rst || frame_rst) paddr <= 24'h0;
    // unique start from bits 3..0, upper bits ignored
    else if (data_go && cmd == fidr_pkg::CMD_UNIQUE)
      paddr <= {20'h0, addr[3:0]};
    // table read starts at the sent address
    else if (data_go && cmd == fidr_pkg::CMD_PARAM_TBL) paddr <= addr;
    else if (st == fidr_pkg::ST_DATA && in_rdy) begin
      unique case (cmd)
        // ident wraps after the two-byte code
        fidr_pkg::CMD_STD_IDENT:
          paddr <= (paddr[1:0] == 2'h2) ? 24'h0 : paddr + 24'h1;
        fidr_pkg::CMD_MAKER_DEV: paddr <= {23'h0, ~paddr[0]};
        fidr_pkg::CMD_UNIQUE: paddr <= {20'h0, paddr[3:0] + 4'h1};
        default: paddr <= paddr + 24'h1;
      endcase
    end
  end

  // flushed on select rise so a new frame never sees stale bytes
  fidr_buf #(.WIDTH(8)) u_buf (
    .clk_sys   (clk_sys),
    .rst       (rst),
    .flush     (frame_rst),
    .in_valid  (st == fidr_pkg::ST_DATA),
    .in_ready  (in_rdy),
    .in_data   (pbyte),
    .out_valid (out_vld),
    .out_ready (pop),
    .out_data  (obyte)
  );

  assign pop = fall && st == fidr_pkg::ST_DATA && bleft == 4'h0 && out_vld;

  // data moves on falling edges only
  always_ff @(posedge clk_sys) begin
    if (rst || frame_rst) begin
      io_out <= 4'h0;
      io_oe  <= 4'h0;
      shreg  <= 8'h00;
      bleft  <= 4'h0;
    end else if (fall && st == fidr_pkg::ST_DATA) begin
      io_oe <= quad ? 4'hf : 4'h2;
      if (bleft == 4'h0) begin
        io_out <= quad ? obyte[7:4] : {2'h0, obyte[7], 1'b0};
        shreg  <= quad ? {obyte[3:0], 4'h0} : {obyte[6:0], 1'b0};
        bleft  <= quad ? 4'h1 : 4'h7;
      end else begin
        io_out <= quad ? shreg[7:4] : {2'h0, shreg[7], 1'b0};
        shreg  <= quad ? {shreg[3:0], 4'h0} : {shreg[6:0], 1'b0};
        bleft  <= bleft - 4'h1;
      end
    end
  end

  // ************************************************************
  // reset, write latch and info-area operations
  // ************************************************************
  logic        area_ok, locked, erase_ok, prog_ok;
  logic [3:0]  locks;
  logic [31:0] erase_cnt;
  logic [11:0] rec_cnt;

  assign locks = {info_area3_lock, info_area2_lock, info_area1_lock, 1'b0};
  assign area_ok =
    addr[23:16] == fidr_pkg::AREA_TOP_VAL &&
    addr[11:10] == fidr_pkg::AREA_GAP_VAL &&
    addr[15:12] >= fidr_pkg::AREA_MIN && addr[15:12] <= fidr_pkg::AREA_MAX;
  // set lock bit blocks writes; area 0 maps to a clear bit
  assign locked = locks[addr[13:12]];
  assign busy_flag = erasing || recovering;

  // erase needs exact frame end; both need latch set, area unlocked
  assign erase_ok = ev && cmd == fidr_pkg::CMD_AREA_ERASE &&
                    st == fidr_pkg::ST_DONE && !over_run && write_latch &&
                    !busy_flag && area_ok && !locked;
  assign prog_ok = ev && cmd == fidr_pkg::CMD_AREA_PROG &&
                   st == fidr_pkg::ST_DONE && write_latch &&
                   !busy_flag && area_ok && !locked;
  assign sw_rst  = ev && cmd == fidr_pkg::CMD_RST && armed;

  // arm only by the frame just before
  always_ff @(posedge clk_sys) begin
    if (rst || rst_evt) armed <= 1'b0;
    else if (ev) armed <= (cmd == fidr_pkg::CMD_RST_ARM);
  end

  always_ff @(posedge clk_sys) begin
    if (rst) reload_cfg <= 1'b0;
    else reload_cfg <= rst_evt;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      erase_start     <= 1'b0;
      info_prog_start <= 1'b0;
      info_area_sel   <= 2'h0;
    end else begin
      erase_start     <= erase_ok;
      info_prog_start <= prog_ok;
      if (erase_ok || prog_ok) info_area_sel <= addr[13:12];
    end
  end

  // latch cleared as the cycle starts
  always_ff @(posedge clk_sys) begin
    if (rst) write_latch <= 1'b0;
    else if (erase_ok || prog_ok) write_latch <= 1'b0;
    else if (ev && cmd == fidr_pkg::CMD_WL_SET && !busy_flag)
      write_latch <= 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (rst || rst_evt) begin
      erasing   <= 1'b0;
      erase_cnt <= 32'h0;
    end else if (erase_ok) begin
      erasing   <= 1'b1;
      erase_cnt <= 32'(ERASE_CYC - 1);
    end else if (erasing) begin
      if (erase_cnt == 32'h0) erasing <= 1'b0;
      else erase_cnt <= erase_cnt - 32'h1;
    end
  end

  // longer recovery after an aborted write
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      recovering <= 1'b0;
      rec_cnt    <= 12'h0;
    end else if (rst_evt) begin
      recovering <= 1'b1;
      rec_cnt    <= erasing ? 12'(fidr_pkg::REC_WRITE_CYC - 1)
                            : 12'(fidr_pkg::REC_OTHER_CYC - 1);
    end else if (recovering && !hw_act) begin
      if (rec_cnt == 12'h0) recovering <= 1'b0;
      else rec_cnt <= rec_cnt - 12'h1;
    end
  end

  // ************************************************************
  // checks
  // ************************************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  chk_float_on_cs: assert property (cs_rise |=> io_oe == 4'h0)
    else $error("output still driven after select rise");
  chk_out_on_fall: assert property (
    $changed(io_out) && !$past(frame_rst) |-> $past(fall))
    else $error("output changed without falling clock edge");
  chk_erase_busy: assert property (
    erase_ok |=> busy_flag && !write_latch && erase_start)
    else $error("erase start did not set busy or clear latch");
  chk_locked_erase: assert property (
    ev && cmd == fidr_pkg::CMD_AREA_ERASE && locked |=> !erase_start)
    else $error("erase of locked area started");
  chk_prog_busy: assert property (
    ev && busy_flag |=> !info_prog_start)
    else $error("program accepted while busy");
  chk_arm_clear: assert property (
    ev && cmd != fidr_pkg::CMD_RST_ARM |=> !armed)
    else $error("reset arm survived another command");
  chk_soft_reset: assert property (
    ev && cmd == fidr_pkg::CMD_RST && armed |=> reload_cfg ##1 !reload_cfg)
    else $error("armed reset did not reload configuration");
  chk_hw_float: assert property (
    hw_act |=> io_oe == 4'h0 && !erasing)
    else $error("reset pulse left output driven or erase running");
endmodule // fidr_core

// *** testbench/fidr_host.sv ***
// host link model: select, clock and data lines of the serial port
`timescale 1ns/10ps
module fidr_host (
  output logic            sck,
  output logic            cs_n,
  output logic      [3:0] io_in,
  input  wire logic [3:0] io_out,
  input  wire logic [3:0] io_oe,
  input  wire logic       quad
);
  logic [7:0] rd_q [$];
  logic [3:0] last_oe;
  // clock stands low outside frames
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    io_in = 4'h0;
  end
  // ************************************************************
  // link cycles
  // ************************************************************
  // sample on rise
  task automatic cyc(input logic [3:0] d, output logic [3:0] q);
    io_in = d;
    #32 sck = 1'b1;
    q = quad ? io_out : {3'h0, io_out[1]};
    last_oe = io_oe;
    #32 sck = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] b, input logic drv,
                      output logic [7:0] r);
    logic [3:0] q;
    logic [3:0] d;
    for (int i = 0; i < (quad ? 2 : 8); i++) begin
      d = quad ? b[7-4*i -: 4] : {~io_in[3:1], b[7-i]};
      cyc(drv ? d : ~io_in, q);
      r = quad ? {r[3:0], q} : {r[6:0], q[0]};
    end
  endtask
  task automatic frame(input logic [7:0] c, input int na,
                       input logic [23:0] a, input int nd, input int nb);
    logic [7:0] r;
    logic [3:0] q;
    rd_q.delete();
    cs_n = 1'b0;
    xfer(c, 1'b1, r);
    for (int i = 0; i < na; i++)
      xfer(a[23-8*i -: 8], 1'b1, r);
    // released lines toggle so stale data never passes
    for (int i = 0; i < nd; i++)
      cyc(~io_in, q);
    for (int i = 0; i < nb; i++) begin
      xfer(8'h00, 1'b0, r);
      rd_q.push_back(r);
    end
    #32 cs_n = 1'b1;
    io_in = ~io_in;
    #200;
  endtask
endmodule // fidr_host

// *** testbench/tb_fidr_core.sv ***
// self-checking bench of the identification and info-area command block
`timescale 1ns/10ps
module tb_fidr_core;
  // identity values below are arbitrary
  localparam logic [7:0]   MK   = 8'h5e;
  localparam logic [7:0]   TY   = 8'h21;
  localparam logic [7:0]   CP   = 8'h0d;
  localparam logic [7:0]   DV   = 8'h7b;
  localparam logic [127:0] UID  = 128'hf0e1d2c3b4a5968778695a4b3c2d1e0f;
  localparam logic [127:0] TBL  = 128'h00112233445566778899aabbccddeeff;
  // short erase keeps the run brief, still longer than one frame
  localparam int           ECYC = 1500;
  logic        clk_sys, rst, rst_pin_n, quad, qe, ded, rdis, ex;
  logic        sck, cs_n, busy, wl, reload, est, pst;
  logic [2:0]  lock;
  logic [1:0]  sel, ar;
  logic [3:0]  io_in, io_out, io_oe;
  logic [7:0]  n_rl, n_er, n_pg, n0;
  logic [23:0] a;
  int          failures, n_compared, sd;
  fidr_core #(.ERASE_CYC(ECYC), .MAKER_CODE(MK), .TYPE_CODE(TY),
    .CAP_CODE(CP), .DEV_CODE(DV), .UNIQUE_NUM(UID), .PARAM_TBL(TBL)) dut (
    .clk_sys(clk_sys), .rst(rst), .sck(sck), .cs_n(cs_n), .io_in(io_in),
    .io_out(io_out), .io_oe(io_oe), .reset_pin_n(rst_pin_n),
    .four_line_cmd_mode(quad), .quad_lines_enable_bit(qe),
    .dedicated_reset_pin(ded), .reset_pin_disable(rdis),
    .info_area1_lock(lock[0]), .info_area2_lock(lock[1]),
    .info_area3_lock(lock[2]), .busy_flag(busy), .write_latch(wl),
    .reload_cfg(reload), .erase_start(est), .info_prog_start(pst),
    .info_area_sel(sel));
  fidr_host h (.sck(sck), .cs_n(cs_n), .io_in(io_in), .io_out(io_out),
    .io_oe(io_oe), .quad(quad));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  always_ff @(posedge clk_sys) begin
    n_rl <= rst ? 8'h00 : n_rl + {7'h00, reload};
    n_er <= rst ? 8'h00 : n_er + {7'h00, est};
    n_pg <= rst ? 8'h00 : n_pg + {7'h00, pst};
  end
  // ************************************************************
  // helpers
  // ************************************************************
  task automatic complete_run;
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic cmp8(input logic [7:0] g, input logic [7:0] e);
    n_compared++;
    if (g !== e) begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic cmp1(input logic g, input logic e);
    cmp8({7'h00, g}, {7'h00, e});
  endtask
  function automatic logic [7:0] eb(logic [7:0] c, logic [23:0] a, int i);
    case (c)
      8'h9f: return (i % 3 == 0) ? MK : (i % 3 == 1) ? TY : CP;
      8'h90: return (i % 2 == 0) ? MK : DV;
      8'h4b: return UID[8 * ((a[3:0] + i) % 16) +: 8];
      default: return TBL[8 * (a[3:0] + i) +: 8];
    endcase
  endfunction
  task automatic rd(input logic [7:0] c, input int na, input logic [23:0] a,
                    input int nd, input int nb);
    h.frame(c, na, a, nd, nb);
    for (int i = 0; i < nb; i++)
      cmp8(h.rd_q[i], eb(c, a, i));
    cmp8({4'h0, h.last_oe}, quad ? 8'h0f : 8'h02);
    cmp8({4'h0, io_oe}, 8'h00);
  endtask
  task automatic cfg(input logic q, input logic e, input logic d,
                     input logic r);
    @(posedge clk_sys);
    #1 quad = q;
    qe = e;
    ded = d;
    rdis = r;
  endtask
  task automatic pin(input int w);
    @(posedge clk_sys);
    #1 rst_pin_n = 1'b0;
    repeat (w) @(posedge clk_sys);
    #1 rst_pin_n = 1'b1;
  endtask
  task automatic idle;
    for (int i = 0; i < 3000 && busy !== 1'b0; i++)
      @(posedge clk_sys) #1;
    cmp1(busy, 1'b0);
  endtask
  initial begin
    #400000;
    failures++;
    complete_run;
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    rst = 1'b1;
    rst_pin_n = 1'b1;
    quad = 1'b0;
    qe = 1'b0;
    ded = 1'b1;
    rdis = 1'b0;
    lock = 3'h0;
    sd = $urandom(23244);
    repeat (10) @(posedge clk_sys);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int m = 0; m < 2; m++) begin
      cfg(m[0], m[0], 1'b1, 1'b0);
      rd(8'h9f, 0, 24'h0, 0, 7);
      rd(8'h90, 3, 24'h0, 0, 4);
      a = 24'($urandom) & 24'hfffe0f;
      rd(8'h4b, 3, a, 8, 18);
      a = 24'($urandom % 12);
      rd(8'h5a, 3, a, 8, 4);
    end
    cfg(1'b0, 1'b0, 1'b1, 1'b0);
    n0 = n_rl;
    h.frame(8'h66, 0, 24'h0, 0, 0);
    h.frame(8'h9f, 0, 24'h0, 0, 1);
    h.frame(8'h99, 0, 24'h0, 0, 0);
    cmp8(n_rl, n0);
    h.frame(8'h66, 0, 24'h0, 0, 0);
    h.frame(8'h99, 0, 24'h0, 0, 0);
    cmp1(busy, 1'b1);
    idle;
    cmp8(n_rl, n0 + 8'h01);
    // order matters: the no-latch case relies on the erase before it
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_sys) #1;
      ar = (k == 5) ? 2'h0 : 2'($urandom_range(3, 1));
      lock = 3'($urandom) & ~(3'h1 << (ar - 2'h1));
      if (k == 2)
        lock = 3'h1 << (ar - 2'h1);
      a = {8'h00, 2'h0, ar, ((k == 4) ? 2'h1 : 2'h0), 10'($urandom)};
      n0 = n_er;
      if (k != 1) begin
        h.frame(8'h06, 0, 24'h0, 0, 0);
        cmp1(wl, 1'b1);
      end
      h.frame(8'h44, 3, a, (k == 3) ? 1 : 0, 0);
      cmp8(n_er, n0 + ((k == 0) ? 8'h01 : 8'h00));
      if (k == 0) begin
        cmp1(busy, 1'b1);
        cmp1(wl, 1'b0);
        cmp8({6'h0, sel}, {6'h0, ar});
        idle;
      end
    end
    @(posedge clk_sys) #1 lock = 3'h0;
    n0 = n_pg;
    h.frame(8'h06, 0, 24'h0, 0, 0);
    h.frame(8'h42, 3, 24'h003000, 0, 0);
    cmp8(n_pg, n0 + 8'h01);
    cmp8({6'h0, sel}, 8'h03);
    h.frame(8'h06, 0, 24'h0, 0, 0);
    h.frame(8'h44, 3, 24'h001000, 0, 0);
    h.frame(8'h42, 3, 24'h002000, 0, 0);
    cmp8(n_pg, n0 + 8'h01);
    n0 = n_rl;
    pin(25);
    repeat (1990) @(posedge clk_sys);
    cmp1(busy, 1'b1);
    idle;
    cmp8(n_rl, n0 + 8'h01);
    for (int k = 0; k < 5; k++) begin
      cfg(1'b0, k == 0 || k == 2, k != 2 && k != 3, k == 1);
      ex = (k == 0 || k == 3);
      n0 = n_rl;
      pin((k == 4) ? 10 : 25);
      repeat (190) @(posedge clk_sys);
      cmp1(busy, ex);
      repeat (30) @(posedge clk_sys);
      cmp1(busy, 1'b0);
      cmp8(n_rl, n0 + {7'h00, ex});
    end
    complete_run;
  end
endmodule // tb_fidr_core
